// ===== core/analog_watchdog_threshold_peak.sv
`timescale 1ns/1ps
module analog_watchdog_threshold_peak (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire awd_pkg::result_t i_result,
  input wire logic [awd_pkg::NUM_CH-1:0] i_analog_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_irq,
  output logic [awd_pkg::STAT_W-1:0] o_event_status
);

  logic [7:0] hyst_reg [awd_pkg::NUM_WATCH];
  logic [7:0] high_reg [awd_pkg::NUM_WATCH];
  logic [7:0] evt_reg [awd_pkg::NUM_WATCH];
  logic [7:0] low_reg [awd_pkg::NUM_WATCH];
  logic [awd_pkg::CODE_W-1:0] peak_reg [awd_pkg::NUM_PEAK];
  logic [awd_pkg::STAT_W-1:0] status_reg;
  logic [awd_pkg::STAT_W-1:0] mask_reg;
  logic [awd_pkg::STAT_W-1:0] event_set;
  logic [7:0] rdata_next;
  logic [awd_pkg::NUM_CH-1:0] sample_ch;

  always_comb
  begin
    sample_ch = '0;
    if (i_result.valid && i_analog_en[i_result.ch])
      sample_ch[i_result.ch] = 1'b1;
  end

  genvar k;
  generate
    for (k = 0; k < awd_pkg::NUM_WATCH; k++)
    begin : g_watch
      localparam int CH = int'(awd_pkg::WATCH_CH_FIRST) + k;
      awd_pkg::watch_cfg_t cfg;

      always_ff @(posedge i_mclk or posedge i_rst)
      begin
        if (i_rst)
        begin
          high_reg[k] <= awd_pkg::RST_HIGH;
          low_reg[k] <= awd_pkg::RST_LOW;
        end
        else if (i_wr)
        begin
          if (i_addr == awd_pkg::OFS_HIGH[k])
            high_reg[k] <= i_wdata;
          if (i_addr == awd_pkg::OFS_LOW[k])
            low_reg[k] <= i_wdata;
        end
      end

      always_ff @(posedge i_mclk or posedge i_rst)
      begin
        if (i_rst)
        begin
          hyst_reg[k] <= awd_pkg::RST_HYST;
          evt_reg[k] <= awd_pkg::RST_EVT;
        end
        else if (i_wr)
        begin
          if (i_addr == awd_pkg::OFS_HYST[k])
            hyst_reg[k] <= i_wdata;
          if (i_addr == awd_pkg::OFS_EVT[k])
            evt_reg[k] <= i_wdata;
        end
      end

      assign cfg = '{
        high_byte: high_reg[k],
        high_nib: hyst_reg[k][awd_pkg::NIB_HI_MSB:awd_pkg::NIB_HI_LSB],
        low_byte: low_reg[k],
        low_nib: evt_reg[k][awd_pkg::NIB_HI_MSB:awd_pkg::NIB_HI_LSB],
        hyst: hyst_reg[k][awd_pkg::NIB_LO_MSB:awd_pkg::NIB_LO_LSB],
        count: evt_reg[k][awd_pkg::NIB_LO_MSB:awd_pkg::NIB_LO_LSB]
      };

      window_watch u_watch (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_cfg(cfg),
        .i_sample(sample_ch[CH]),
        .i_code(i_result.code),
        .o_high_event(event_set[2*k+awd_pkg::STAT_HIGH_OFS]),
        .o_low_event(event_set[2*k+awd_pkg::STAT_LOW_OFS])
      );
    end

    for (k = 0; k < awd_pkg::NUM_PEAK; k++)
    begin : g_peak
      localparam int CH = int'(awd_pkg::PEAK_CH_FIRST) + k;
      logic rd_hit;
      logic [awd_pkg::CODE_W-1:0] base;

      assign rd_hit = i_rd && (i_addr == awd_pkg::OFS_PEAK_LO[k] ||
                               i_addr == awd_pkg::OFS_PEAK_HI[k]);
      assign base = rd_hit ? awd_pkg::PEAK_CLEAR : peak_reg[k];

      // keep largest code
      // A sample in the read cycle is kept, so no peak is lost
      always_ff @(posedge i_mclk or posedge i_rst)
      begin
        if (i_rst)
          peak_reg[k] <= awd_pkg::PEAK_CLEAR;
        else if (sample_ch[CH] && i_result.code > base)
          peak_reg[k] <= i_result.code;
        else
          peak_reg[k] <= base;
      end
    end
  endgenerate

  // sticky event flags
  // Hardware set wins over a write-one clear in the same cycle
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      status_reg <= awd_pkg::RST_STATUS;
    else if (i_wr && i_addr == awd_pkg::OFS_EVT_STATUS)
      status_reg <= (status_reg & ~i_wdata[awd_pkg::STAT_W-1:0]) | event_set;
    else
      status_reg <= status_reg | event_set;
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      mask_reg <= awd_pkg::RST_MASK;
    else if (i_wr && i_addr == awd_pkg::OFS_EVT_MASK)
      mask_reg <= i_wdata[awd_pkg::STAT_W-1:0];
  end

  assign o_irq = |(status_reg & mask_reg);
  assign o_event_status = status_reg;

  // Read mux; peak bytes show the value before the clear lands
  always_comb
  begin
    rdata_next = 8'h00;
    for (int w = 0; w < awd_pkg::NUM_WATCH; w++)
    begin
      if (i_addr == awd_pkg::OFS_HYST[w])
        rdata_next = hyst_reg[w];
      if (i_addr == awd_pkg::OFS_HIGH[w])
        rdata_next = high_reg[w];
      if (i_addr == awd_pkg::OFS_EVT[w])
        rdata_next = evt_reg[w];
      if (i_addr == awd_pkg::OFS_LOW[w])
        rdata_next = low_reg[w];
    end
    for (int p = 0; p < awd_pkg::NUM_PEAK; p++)
    begin
      if (i_addr == awd_pkg::OFS_PEAK_LO[p])
        rdata_next = peak_reg[p][7:0];
      if (i_addr == awd_pkg::OFS_PEAK_HI[p])
        rdata_next = {4'h0, peak_reg[p][awd_pkg::CODE_W-1:8]};
    end
    if (i_addr == awd_pkg::OFS_EVT_STATUS)
      rdata_next = {{(8-awd_pkg::STAT_W){1'b0}}, status_reg};
    if (i_addr == awd_pkg::OFS_EVT_MASK)
      rdata_next = {{(8-awd_pkg::STAT_W){1'b0}}, mask_reg};
  end

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
      o_rdata <= 8'h00;
    else if (i_rd)
      o_rdata <= rdata_next;
    else
      o_rdata <= 8'h00;
  end

endmodule

// ===== core/awd_pkg.sv
package awd_pkg;

  localparam int CODE_W = 12;
  localparam int NUM_CH = 8;
  localparam int NUM_WATCH = 2;
  localparam int NUM_PEAK = 2;
  localparam logic [2:0] WATCH_CH_FIRST = 3'h6;
  localparam logic [2:0] PEAK_CH_FIRST = 3'h0;

  // Register offsets, one byte each
  localparam logic [7:0] OFS_CH6_HYST = 8'h38;
  localparam logic [7:0] OFS_CH6_HIGH = 8'h39;
  localparam logic [7:0] OFS_CH6_EVT = 8'h3A;
  localparam logic [7:0] OFS_CH6_LOW = 8'h3B;
  localparam logic [7:0] OFS_CH7_HYST = 8'h3C;
  localparam logic [7:0] OFS_CH7_HIGH = 8'h3D;
  localparam logic [7:0] OFS_CH7_EVT = 8'h3E;
  localparam logic [7:0] OFS_CH7_LOW = 8'h3F;
  localparam logic [7:0] OFS_CH0_PEAK_LO = 8'h60;
  localparam logic [7:0] OFS_CH0_PEAK_HI = 8'h61;
  localparam logic [7:0] OFS_CH1_PEAK_LO = 8'h62;
  localparam logic [7:0] OFS_CH1_PEAK_HI = 8'h63;
  localparam logic [7:0] OFS_EVT_STATUS = 8'h70;
  localparam logic [7:0] OFS_EVT_MASK = 8'h71;

  localparam logic [7:0] OFS_HYST [NUM_WATCH] = '{OFS_CH6_HYST, OFS_CH7_HYST};
  localparam logic [7:0] OFS_HIGH [NUM_WATCH] = '{OFS_CH6_HIGH, OFS_CH7_HIGH};
  localparam logic [7:0] OFS_EVT [NUM_WATCH] = '{OFS_CH6_EVT, OFS_CH7_EVT};
  localparam logic [7:0] OFS_LOW [NUM_WATCH] = '{OFS_CH6_LOW, OFS_CH7_LOW};
  localparam logic [7:0] OFS_PEAK_LO [NUM_PEAK] =
    '{OFS_CH0_PEAK_LO, OFS_CH1_PEAK_LO};
  localparam logic [7:0] OFS_PEAK_HI [NUM_PEAK] =
    '{OFS_CH0_PEAK_HI, OFS_CH1_PEAK_HI};

  // Reset values
  localparam logic [7:0] RST_HYST = 8'hF0;
  localparam logic [7:0] RST_HIGH = 8'hFF;
  localparam logic [7:0] RST_EVT = 8'h00;
  localparam logic [7:0] RST_LOW = 8'h00;
  localparam logic [3:0] RST_STATUS = 4'h0;
  localparam logic [3:0] RST_MASK = 4'h0;
  localparam logic [CODE_W-1:0] PEAK_CLEAR = 12'h000;

  // Field positions within the byte registers, hysteresis scaling and the full-scale code
  localparam int NIB_HI_MSB = 7;
  localparam int NIB_HI_LSB = 4;
  localparam int NIB_LO_MSB = 3;
  localparam int NIB_LO_LSB = 0;
  localparam int HYST_SHIFT = 3;
  localparam int HYST_W = 7;
  localparam logic [CODE_W-1:0] CODE_MAX = 12'hFFF;

  // Status bit layout: two bits per watched channel
  localparam int STAT_W = 2 * NUM_WATCH;
  localparam int STAT_HIGH_OFS = 0;
  localparam int STAT_LOW_OFS = 1;

  typedef struct packed {
    logic valid;
    logic [2:0] ch;
    logic [CODE_W-1:0] code;
  } result_t;

  typedef struct packed {
    logic [7:0] high_byte;
    logic [3:0] high_nib;
    logic [7:0] low_byte;
    logic [3:0] low_nib;
    logic [3:0] hyst;
    logic [3:0] count;
  } watch_cfg_t;

endpackage

// ===== core/window_watch.sv
`timescale 1ns/1ps
module window_watch (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire awd_pkg::watch_cfg_t i_cfg,
  input wire logic i_sample,
  input wire logic [awd_pkg::CODE_W-1:0] i_code,
  output logic o_high_event,
  output logic o_low_event
);

  logic [awd_pkg::CODE_W-1:0] hi_th;
  logic [awd_pkg::CODE_W-1:0] lo_th;
  logic [awd_pkg::CODE_W-1:0] hyst_amt;
  logic [awd_pkg::CODE_W-1:0] hi_release;
  logic [awd_pkg::CODE_W:0] lo_sum;
  logic [awd_pkg::CODE_W-1:0] lo_release;
  logic above;
  logic below;
  logic alarm_hi_reg;
  logic alarm_lo_reg;
  logic [3:0] cnt_hi_reg;
  logic [3:0] cnt_lo_reg;

  assign hi_th = {i_cfg.high_byte, i_cfg.high_nib};
  assign lo_th = {i_cfg.low_byte, i_cfg.low_nib};
  assign hyst_amt = {{(awd_pkg::CODE_W-awd_pkg::HYST_W){1'b0}},
                     i_cfg.hyst, {awd_pkg::HYST_SHIFT{1'b0}}};
  assign hi_release = (hi_th > hyst_amt) ? hi_th - hyst_amt : '0;
  assign lo_sum = {1'b0, lo_th} + {1'b0, hyst_amt};
  // Saturate so a margin near full scale never wraps to a tiny value
  assign lo_release = lo_sum[awd_pkg::CODE_W] ? awd_pkg::CODE_MAX
                                              : lo_sum[awd_pkg::CODE_W-1:0];
  assign above = i_code > hi_th;
  assign below = i_code < lo_th;

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      alarm_hi_reg <= 1'b0;
      cnt_hi_reg <= 4'h0;
      o_high_event <= 1'b0;
    end
    else
    begin
      o_high_event <= 1'b0;
      if (i_sample)
      begin
        if (alarm_hi_reg)
        begin
          cnt_hi_reg <= 4'h0;
          if (i_code < hi_release)
            alarm_hi_reg <= 1'b0;
        end
        else if (above)
        begin
          if (cnt_hi_reg == i_cfg.count)
          begin
            o_high_event <= 1'b1;
            alarm_hi_reg <= 1'b1;
            cnt_hi_reg <= 4'h0;
          end
          else
            cnt_hi_reg <= cnt_hi_reg + 4'h1;
        end
        else
          cnt_hi_reg <= 4'h0;
      end
    end
  end

  always_ff @(posedge i_mclk or posedge i_rst)
  begin
    if (i_rst)
    begin
      alarm_lo_reg <= 1'b0;
      cnt_lo_reg <= 4'h0;
      o_low_event <= 1'b0;
    end
    else
    begin
      o_low_event <= 1'b0;
      if (i_sample)
      begin
        if (alarm_lo_reg)
        begin
          cnt_lo_reg <= 4'h0;
          if (i_code > lo_release)
            alarm_lo_reg <= 1'b0;
        end
        else if (below)
        begin
          if (cnt_lo_reg == i_cfg.count)
          begin
            o_low_event <= 1'b1;
            alarm_lo_reg <= 1'b1;
            cnt_lo_reg <= 4'h0;
          end
          else
            cnt_lo_reg <= cnt_lo_reg + 4'h1;
        end
        else
          cnt_lo_reg <= 4'h0;
      end
    end
  end

endmodule

// ===== verification/analog_watchdog_threshold_peak_test.sv
`timescale 1ns/1ps
module analog_watchdog_threshold_peak_test;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  awd_pkg::result_t i_result = '0;
  logic [7:0] i_analog_en = 8'hFF;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] o_rdata;
  logic o_irq;
  logic [3:0] o_event_status;
  logic rd_d = 1'b0;
  logic [7:0] exp_q[$];
  int error_cnt = 0;
  int cmp_count = 0;
  logic [7:0] rst_v [4] = '{8'hF0, 8'hFF, 8'h00, 8'h00};
  logic [11:0] pk;
  logic [11:0] c;
  logic [7:0] v;
  int seed;
  always #10 i_mclk = ~i_mclk;
  analog_watchdog_threshold_peak analog_watchdog_threshold_peak_i (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_result(i_result),
    .i_analog_en(i_analog_en), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
    .o_event_status(o_event_status));
  task chk(input string nm, input logic [7:0] e, input logic [7:0] s);
    cmp_count++;
    if (s !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
      error_cnt++;
    end
  endtask
  task print_verdict;
    $display("errors %0d compares %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task op(input logic w, input logic r, input logic [7:0] a,
    input logic [7:0] d, input awd_pkg::result_t res);
    @(posedge i_mclk);
    i_wr <= w;
    i_rd <= r;
    i_addr <= a;
    i_wdata <= d;
    i_result <= res;
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    op(1'b1, 1'b0, a, d, '0);
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    op(1'b0, 1'b1, a, 8'h00, '0);
    exp_q.push_back(e);
  endtask
  task idle(input int n);
    repeat (n) op(1'b0, 1'b0, 8'h00, 8'h00, '0);
  endtask
  task smp(input logic [2:0] ch, input logic [11:0] code);
    op(1'b0, 1'b0, 8'h00, 8'h00, '{1'b1, ch, code});
  endtask
  // Status output is looked at mid-cycle, then read back over the bus
  task st(input logic [7:0] e);
    idle(3);
    @(negedge i_mclk);
    chk("status", e, {4'h0, o_event_status});
    rd(8'h70, e);
  endtask
  // One idle edge first, so the strobe before it is taken and then lowered
  task irq_is(input logic e);
    idle(1);
    @(negedge i_mclk);
    chk("irq", {7'h00, e}, {7'h00, o_irq});
  endtask
  // Read data lands one cycle after the strobe; oldest note matches it
  always @(posedge i_mclk)
  begin
    if (rd_d)
      chk("rdata", exp_q.pop_front(), o_rdata);
    rd_d <= i_rd;
  end
  initial
  begin
    repeat (5000) @(posedge i_mclk);
    error_cnt++;
    print_verdict();
  end
  initial
  begin
    seed = $urandom(78);
    repeat (8) @(posedge i_mclk);
    i_rst <= 1'b0;
    for (int i = 0; i < 8; i++) rd(8'(8'h38 + i), rst_v[i % 4]);
    for (int i = 0; i < 4; i++) rd(8'(8'h60 + i), 8'h00);
    wr(8'h00, 8'hFF);
    rd(8'h00, 8'h00);
    for (int i = 0; i < 8; i++)
    begin
      v = 8'($urandom);
      wr(8'(8'h38 + i), v);
      rd(8'(8'h38 + i), v);
    end
    for (int i = 0; i < 8; i++) wr(8'(8'h38 + i), rst_v[i % 4]);
    wr(8'h71, 8'h0F);
    wr(8'h3D, 8'h80);
    wr(8'h3C, 8'h50);
    smp(3'h7, 12'h805);
    st(8'h00);
    smp(3'h7, 12'h806);
    st(8'h04);
    irq_is(1'b1);
    wr(8'h71, 8'h00);
    irq_is(1'b0);
    wr(8'h71, 8'h0F);
    wr(8'h70, 8'h04);
    st(8'h00);
    wr(8'h3C, 8'h51);
    smp(3'h7, 12'h7FE);
    smp(3'h7, 12'h806);
    st(8'h00);
    smp(3'h7, 12'h7FC);
    smp(3'h7, 12'h806);
    st(8'h04);
    wr(8'h70, 8'h0F);
    smp(3'h7, 12'h000);
    wr(8'h3E, 8'h02);
    smp(3'h7, 12'h900);
    smp(3'h6, 12'h500);
    smp(3'h7, 12'h900);
    st(8'h00);
    smp(3'h7, 12'h900);
    st(8'h04);
    wr(8'h3B, 8'h40);
    wr(8'h3A, 8'h30);
    smp(3'h6, 12'h403);
    st(8'h04);
    smp(3'h6, 12'h402);
    st(8'h06);
    wr(8'h70, 8'h0F);
    smp(3'h7, 12'h000);
    wr(8'h3E, 8'h00);
    i_analog_en <= 8'h7F;
    smp(3'h7, 12'h900);
    st(8'h00);
    i_analog_en <= 8'hFF;
    smp(3'h7, 12'h900);
    st(8'h04);
    // Ch7 low side and ch6 high side, the two events not yet raised
    wr(8'h70, 8'h0F);
    wr(8'h3F, 8'h10);
    wr(8'h39, 8'h80);
    smp(3'h7, 12'h0FF);
    smp(3'h6, 12'h810);
    st(8'h09);
    smp(3'h0, 12'h123);
    smp(3'h0, 12'hABC);
    smp(3'h0, 12'h456);
    rd(8'h60, 8'hBC);
    rd(8'h61, 8'h00);
    rd(8'h61, 8'h00);
    pk = 12'h000;
    for (int i = 0; i < 6; i++)
    begin
      c = 12'($urandom);
      smp(3'h1, c);
      if (c > pk)
        pk = c;
    end
    rd(8'h63, {4'h0, pk[11:8]});
    rd(8'h62, 8'h00);
    idle(3);
    print_verdict();
  end
endmodule

// ===== verification/awd_properties.sv
`timescale 1ns/1ps
module awd_properties (
  input wire logic i_mclk,
  input wire logic i_rst,
  input wire awd_pkg::result_t i_result,
  input wire logic [awd_pkg::NUM_CH-1:0] i_analog_en,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic o_irq,
  input wire logic [awd_pkg::STAT_W-1:0] o_event_status
);
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);
  sequence s_peak_rd;
    i_rd && i_addr == awd_pkg::OFS_CH0_PEAK_HI && !i_result.valid;
  endsequence
  sequence s_stat_rd;
    i_rd && i_addr == awd_pkg::OFS_EVT_STATUS;
  endsequence
  a_rdata_idle: assert property (
    !$past(i_rd) |-> o_rdata == 8'h00)
    else $error("read data not zero outside a reply");
  a_event_cause: assert property (
    (o_event_status & ~$past(o_event_status)) != '0 |->
      $past(i_result.valid && i_analog_en[i_result.ch] &&
      i_result.ch[2:1] == 2'b11, 2))
    else $error("event set without a watched analog sample");
  a_peak_clear: assert property (
    s_peak_rd ##1 s_peak_rd |=> o_rdata == 8'h00)
    else $error("peak not cleared by read");
  a_peak_nibble: assert property (
    $past(i_rd && i_addr == awd_pkg::OFS_CH0_PEAK_HI) |->
      o_rdata[7:4] == 4'h0)
    else $error("peak high byte upper bits set");
  a_stat_read: assert property (
    s_stat_rd |=> o_rdata == {4'h0, $past(o_event_status)})
    else $error("status read mismatch");
  a_stat_sticky: assert property (
    !$past(i_wr && i_addr == awd_pkg::OFS_EVT_STATUS) |->
      (o_event_status & $past(o_event_status)) == $past(o_event_status))
    else $error("status bit dropped without clear");
  a_irq_status: assert property (
    o_irq |-> o_event_status != '0)
    else $error("interrupt without status");
  a_write_read: assert property (
    i_wr && i_addr == awd_pkg::OFS_CH7_HIGH ##1
      i_rd && i_addr == awd_pkg::OFS_CH7_HIGH |=>
      o_rdata == $past(i_wdata, 2))
    else $error("threshold byte readback mismatch");
endmodule
bind analog_watchdog_threshold_peak awd_properties awd_properties_i (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_result(i_result),
  .i_analog_en(i_analog_en), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
  .o_event_status(o_event_status));
